//--- bkr_top.sv
// Low-voltage buck configuration, mode control and Wishbone register file
`timescale 1ns/1ps
module bkr_top
    import bkr_pkg::*;
#(
    parameter int DISCH_CYCLES = BKR_DISCH_CYC
)(
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        SYS_ON,
    input  wire logic        STANDBY,
    input  wire logic        IN_PWRUP_SEQ,
    input  wire logic [4:0]  VOLT_DEFAULT_FUSE,
    input  wire logic [2:0]  PHASE_DEFAULT_FUSE,
    input  wire logic [1:0]  INDUCTOR_FUSE_SEL,
    output logic             REG_EN,
    output logic             DISCHARGE,
    output logic      [1:0]  OP_MODE,
    output logic             PWM_SEL,
    output logic             PFM_SEL,
    output logic             SKIP_SEL,
    output logic      [12:0] VOUT_MV,
    output logic      [12:0] PEAK_LIMIT_MA,
    output logic      [8:0]  PHASE_DEG,
    output logic      [10:0] INDUCTOR_NH,
    output logic             INDUCTOR_RSVD,
    output logic             IRQ_OUT_N
);
    function automatic logic [12:0] volt_mv(input logic [4:0] code);
        logic [12:0] mv;
        case (code)
            5'h00: mv = 13'd1000;
            5'h01: mv = 13'd1100;
            5'h02: mv = 13'd1200;
            5'h03: mv = 13'd1250;
            5'h04: mv = 13'd1300;
            5'h05: mv = 13'd1350;
            5'h06: mv = 13'd1500;
            5'h07: mv = 13'd1600;
            5'h08: mv = 13'd1800;
            5'h09: mv = 13'd1850;
            5'h0a: mv = 13'd2000;
            5'h0b: mv = 13'd2100;
            5'h0c: mv = 13'd2150;
            5'h0d: mv = 13'd2250;
            5'h0e: mv = 13'd2300;
            5'h0f: mv = 13'd2400;
            5'h10: mv = 13'd2500;
            5'h11: mv = 13'd2800;
            5'h12: mv = 13'd3150;
            5'h13: mv = 13'd3200;
            5'h14: mv = 13'd3250;
            5'h15: mv = 13'd3300;
            5'h16: mv = 13'd3350;
            5'h17: mv = 13'd3400;
            5'h18: mv = 13'd3500;
            5'h19: mv = 13'd3800;
            5'h1a: mv = 13'd4000;
            default: mv = 13'd4100;
        endcase
        return mv;
    endfunction : volt_mv
    function automatic logic [12:0] limit_ma(input logic [1:0] sel);
        logic [12:0] ma;
        case (sel)
            2'h0: ma = 13'd2100;
            2'h1: ma = 13'd2600;
            2'h2: ma = 13'd3000;
            default: ma = 13'd4500;
        endcase
        return ma;
    endfunction : limit_ma
    function automatic logic [8:0] phase_deg(input logic [2:0] sel);
        logic [8:0] deg;
        deg = 9'd0;
        if (sel != 3'h7)
            deg = 9'(({6'd0, sel} + 9'd1) * 9'd45);
        return deg;
    endfunction : phase_deg
    function automatic logic [10:0] ind_nh(input logic [1:0] sel);
        logic [10:0] nh;
        case (sel)
            2'h0: nh = 11'd1000;
            2'h1: nh = 11'd470;
            2'h2: nh = 11'd1500;
            default: nh = 11'd0;
        endcase
        return nh;
    endfunction : ind_nh
    // Pin synchronisers
    logic [1:0]  sys_on_meta_ff;
    logic [1:0]  stby_meta_ff;
    logic [1:0]  seq_meta_ff;
    logic [4:0]  vfuse_meta_ff;
    logic [4:0]  vfuse_ff;
    logic [2:0]  pfuse_meta_ff;
    logic [2:0]  pfuse_ff;
    logic [1:0]  ifuse_meta_ff;
    logic [1:0]  ifuse_ff;
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            sys_on_meta_ff <= 2'h0;
            stby_meta_ff   <= 2'h0;
            seq_meta_ff    <= 2'h0;
            vfuse_meta_ff  <= 5'h00;
            vfuse_ff       <= 5'h00;
            pfuse_meta_ff  <= 3'h0;
            pfuse_ff       <= 3'h0;
            ifuse_meta_ff  <= 2'h0;
            ifuse_ff       <= 2'h0;
        end
        else
        begin
            sys_on_meta_ff <= {sys_on_meta_ff[0], SYS_ON};
            stby_meta_ff   <= {stby_meta_ff[0], STANDBY};
            seq_meta_ff    <= {seq_meta_ff[0], IN_PWRUP_SEQ};
            vfuse_meta_ff  <= VOLT_DEFAULT_FUSE;
            vfuse_ff       <= vfuse_meta_ff;
            pfuse_meta_ff  <= PHASE_DEFAULT_FUSE;
            pfuse_ff       <= pfuse_meta_ff;
            ifuse_meta_ff  <= INDUCTOR_FUSE_SEL;
            ifuse_ff       <= ifuse_meta_ff;
        end
    end
    wire sys_on_s = sys_on_meta_ff[1];
    wire stby_s   = stby_meta_ff[1];
    wire seq_s    = seq_meta_ff[1];
    // Bus decode
    logic        ack_ff;
    logic [31:0] rd_ff;
    wire req      = WB_CYC_I & WB_STB_I;
    wire wr_fire  = req & WB_WE_I & ack_ff;
    wire hit_volt = WB_ADR_I == BKR_OFS_VOLT;
    wire hit_mode = WB_ADR_I == BKR_OFS_MODE;
    wire hit_cfg  = WB_ADR_I == BKR_OFS_CFG;
    wire hit_stat = WB_ADR_I == BKR_OFS_STAT;
    wire hit_irq  = WB_ADR_I == BKR_OFS_IRQ;
    wire wr_b0    = wr_fire & WB_SEL_I[0];
    wire wr_b1    = wr_fire & WB_SEL_I[1];
    // Control state
    bkr_state_t  state_ff;
    bkr_state_t  nxt_state;
    logic [1:0]  init_cnt_ff;
    logic [11:0] dis_cnt_ff;
    logic [11:0] nxt_dis_cnt;
    logic [4:0]  code_ff;
    logic [4:0]  app_code_ff;
    logic [4:0]  nxt_app_code;
    logic [1:0]  run_op_ff;
    logic [1:0]  stby_op_ff;
    logic [1:0]  ilim_ff;
    logic [2:0]  phase_ff;
    logic [1:0]  prev_op_ff;
    logic        flag_ff;
    logic        mask_ff;
    wire [1:0] eff_op   = !sys_on_s ? BKR_OP_OFF : (stby_s ? stby_op_ff : run_op_ff);
    wire       running  = state_ff == BKR_ST_RUN;
    wire       disch    = state_ff == BKR_ST_DISCH;
    // enable follows mode in run state only, code untouched
    wire       en_now   = running & (eff_op != BKR_OP_OFF);
    wire       code_chg = wr_b0 & hit_volt & (WB_DAT_I[4:0] != code_ff);
    wire       dis_done = dis_cnt_ff == 12'(DISCH_CYCLES - 1);
    wire       init_end = state_ff == BKR_ST_INIT && init_cnt_ff == 2'(BKR_FUSE_SETTLE);
    wire       op_evt   = !(state_ff == BKR_ST_INIT) & (eff_op != prev_op_ff);
    wire       flag_clr = wr_b0 & hit_irq & WB_DAT_I[BKR_POS_FLAG];
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_dis_cnt  = dis_cnt_ff;
        nxt_app_code = app_code_ff;
        case (state_ff)
            BKR_ST_INIT:
            begin
                if (init_end)
                begin
                    nxt_state    = BKR_ST_RUN;
                    nxt_app_code = vfuse_ff;
                end
            end
            BKR_ST_RUN:
            begin
                // discharge before moving to new level
                if (code_chg && sys_on_s && en_now)
                begin
                    nxt_state   = BKR_ST_DISCH;
                    nxt_dis_cnt = 12'h000;
                end
                else
                    nxt_app_code = code_ff;
            end
            BKR_ST_DISCH:
            begin
                nxt_dis_cnt = 12'(dis_cnt_ff + 12'h001);
                if (dis_done)
                begin
                    nxt_state    = BKR_ST_RUN;
                    nxt_app_code = code_ff;
                end
            end
            default:
                nxt_state = BKR_ST_INIT;
        endcase
    end
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state_ff    <= BKR_ST_INIT;
            init_cnt_ff <= 2'h0;
            dis_cnt_ff  <= 12'h000;
            app_code_ff <= BKR_RST_CODE;
            prev_op_ff  <= BKR_RST_OP;
            flag_ff     <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            init_cnt_ff <= init_end ? init_cnt_ff : 2'(init_cnt_ff + 2'h1);
            dis_cnt_ff  <= nxt_dis_cnt;
            app_code_ff <= nxt_app_code;
            prev_op_ff  <= (state_ff == BKR_ST_INIT) ? eff_op : prev_op_ff ^ (eff_op ^ prev_op_ff);
            // sticky flag, set beats clear so a racing event is kept
            flag_ff     <= op_evt | (flag_ff & ~flag_clr);
        end
    end
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            code_ff    <= BKR_RST_CODE;
            run_op_ff  <= BKR_RST_OP;
            stby_op_ff <= BKR_RST_OP;
            ilim_ff    <= BKR_RST_ILIM;
            phase_ff   <= BKR_RST_PHASE;
            mask_ff    <= BKR_RST_MASK;
        end
        else if (init_end)
        begin
            code_ff    <= vfuse_ff;
            // run mode default from sequence membership
            run_op_ff  <= seq_s ? BKR_OP_SEQ : BKR_OP_OFF;
            stby_op_ff <= seq_s ? BKR_OP_SEQ : BKR_OP_OFF;
            phase_ff   <= pfuse_ff;
        end
        else if (state_ff != BKR_ST_INIT)
        begin
            if (wr_b0 && hit_volt)
                code_ff <= WB_DAT_I[4:0];
            if (wr_b0 && hit_mode)
            begin
                run_op_ff  <= WB_DAT_I[BKR_POS_RUN +: 2];
                stby_op_ff <= WB_DAT_I[BKR_POS_STBY +: 2];
            end
            if (wr_b0 && hit_cfg)
                ilim_ff <= WB_DAT_I[BKR_POS_ILIM +: 2];
            if (wr_b1 && hit_cfg)
                phase_ff <= WB_DAT_I[BKR_POS_PHASE +: 3];
            if (wr_b1 && hit_irq)
                mask_ff <= WB_DAT_I[BKR_POS_MASK];
        end
    end
    wire [31:0] stat_word = (32'(eff_op) << BKR_POS_OP)
                          | (32'(stby_s) << BKR_POS_SBY)
                          | (32'(disch) << BKR_POS_DIS)
                          | (32'(en_now) << BKR_POS_EN)
                          | (32'(ifuse_ff) << BKR_POS_IND)
                          | (32'(app_code_ff) << BKR_POS_ACODE);
    wire [31:0] rd_mux = hit_volt ? 32'(code_ff)
                       : hit_mode ? (32'(run_op_ff) << BKR_POS_RUN) | (32'(stby_op_ff) << BKR_POS_STBY)
                       : hit_cfg  ? (32'(ilim_ff) << BKR_POS_ILIM) | (32'(phase_ff) << BKR_POS_PHASE)
                       : hit_stat ? stat_word
                       : hit_irq  ? (32'(flag_ff) << BKR_POS_FLAG) | (32'(mask_ff) << BKR_POS_MASK)
                       : 32'h0000_0000;
    // Registered outputs toward the power stage
    logic [1:0]  op_out_ff;
    logic        en_out_ff;
    logic        dis_out_ff;
    logic [12:0] vout_ff;
    logic [12:0] lim_ff;
    logic [8:0]  deg_ff;
    logic [10:0] nh_ff;
    logic        irq_n_ff;
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            op_out_ff  <= BKR_OP_OFF;
            en_out_ff  <= 1'b0;
            dis_out_ff <= 1'b0;
            vout_ff    <= 13'd0;
            lim_ff     <= 13'd0;
            deg_ff     <= 9'd0;
            nh_ff      <= 11'd0;
            irq_n_ff   <= 1'b1;
            ack_ff     <= 1'b0;
            rd_ff      <= 32'h0000_0000;
        end
        else
        begin
            op_out_ff  <= en_now ? eff_op : BKR_OP_OFF;
            en_out_ff  <= en_now;
            dis_out_ff <= disch;
            vout_ff    <= volt_mv(app_code_ff);
            lim_ff     <= limit_ma(ilim_ff);
            deg_ff     <= phase_deg(phase_ff);
            nh_ff      <= ind_nh(ifuse_ff);
            irq_n_ff   <= ~(flag_ff & ~mask_ff);
            // Ack one cycle after request, dropped the cycle after
            ack_ff     <= req & ~ack_ff;
            rd_ff      <= (req & ~ack_ff) ? rd_mux : rd_ff;
        end
    end
    assign WB_DAT_O      = rd_ff;
    assign WB_ACK_O      = ack_ff;
    assign REG_EN        = en_out_ff;
    assign DISCHARGE     = dis_out_ff;
    assign OP_MODE       = op_out_ff;
    assign PWM_SEL       = op_out_ff == BKR_OP_PWM;
    assign PFM_SEL       = op_out_ff == BKR_OP_PFM;
    assign SKIP_SEL      = op_out_ff == BKR_OP_SKIP;
    assign VOUT_MV       = vout_ff;
    assign PEAK_LIMIT_MA = lim_ff;
    assign PHASE_DEG     = deg_ff;
    assign INDUCTOR_NH   = nh_ff;
    assign INDUCTOR_RSVD = nh_ff == 11'd0;
    assign IRQ_OUT_N     = irq_n_ff;
endmodule : bkr_top

//--- bkr_pkg.sv
// Shared constants for the low-voltage buck configuration block
package bkr_pkg;
    // Register byte offsets
    localparam logic [7:0] BKR_OFS_VOLT = 8'h00;
    localparam logic [7:0] BKR_OFS_MODE = 8'h04;
    localparam logic [7:0] BKR_OFS_CFG  = 8'h08;
    localparam logic [7:0] BKR_OFS_STAT = 8'h0c;
    localparam logic [7:0] BKR_OFS_IRQ  = 8'h10;
    // Field positions
    localparam int BKR_POS_RUN    = 0;
    localparam int BKR_POS_STBY   = 2;
    localparam int BKR_POS_ILIM   = 0;
    localparam int BKR_POS_PHASE  = 8;
    localparam int BKR_POS_OP     = 0;
    localparam int BKR_POS_SBY    = 2;
    localparam int BKR_POS_DIS    = 3;
    localparam int BKR_POS_EN     = 4;
    localparam int BKR_POS_IND    = 5;
    localparam int BKR_POS_ACODE  = 8;
    localparam int BKR_POS_FLAG   = 0;
    localparam int BKR_POS_MASK   = 8;
    // Reset values and strap default mode
    localparam logic [4:0] BKR_RST_CODE  = 5'h00;
    localparam logic [1:0] BKR_RST_OP    = 2'h0;
    localparam logic [1:0] BKR_RST_ILIM  = 2'h0;
    localparam logic [2:0] BKR_RST_PHASE = 3'h7;
    localparam logic [1:0] BKR_OP_SEQ    = 2'h3;
    localparam logic       BKR_RST_MASK  = 1'b0;
    // Operating modes
    localparam logic [1:0] BKR_OP_OFF  = 2'h0;
    localparam logic [1:0] BKR_OP_PWM  = 2'h1;
    localparam logic [1:0] BKR_OP_PFM  = 2'h2;
    localparam logic [1:0] BKR_OP_SKIP = 2'h3;
    // Timing
    localparam int BKR_CLK_MHZ       = 10;
    localparam int BKR_DISCH_US      = 200;
    localparam int BKR_DISCH_CYC     = BKR_DISCH_US * BKR_CLK_MHZ;
    localparam int BKR_FUSE_SETTLE   = 2;
    typedef enum logic [1:0] {BKR_ST_INIT, BKR_ST_RUN, BKR_ST_DISCH} bkr_state_t;
endpackage : bkr_pkg

//--- bkr_top_sva.sv
// Port-level checker for the buck configuration block
`timescale 1ns/1ps
module bkr_top_sva
    import bkr_pkg::*;
#(
    parameter int DISCH_CYCLES = BKR_DISCH_CYC
)(
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic        WB_ACK_O,
    input wire logic        STANDBY,
    input wire logic        REG_EN,
    input wire logic        DISCHARGE,
    input wire logic [1:0]  OP_MODE,
    input wire logic        PWM_SEL,
    input wire logic        PFM_SEL,
    input wire logic        SKIP_SEL,
    input wire logic [12:0] VOUT_MV,
    input wire logic        IRQ_OUT_N
);
    logic [15:0] dis_cnt_ff;
    logic [15:0] nxt_dis_cnt;
    wire logic   wr_req;

    assign wr_req      = WB_CYC_I && WB_STB_I && WB_WE_I;
    assign nxt_dis_cnt = DISCHARGE ? dis_cnt_ff + 16'h0001 : 16'h0000;

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            dis_cnt_ff <= 16'h0000;
        else
            dis_cnt_ff <= nxt_dis_cnt;
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence disch_end;
        $fell(DISCHARGE);
    endsequence
    sequence reg_back;
        ##[0:2] REG_EN;
    endsequence

    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack without request");
    AST_DIS_OFF: assert property (DISCHARGE |-> !REG_EN) else $error("enabled while discharging");
    AST_DIS_LEN: assert property (dis_cnt_ff <= DISCH_CYCLES + 2) else $error("discharge too long");
    AST_DIS_END: assert property (disch_end |-> reg_back) else $error("no re-enable after discharge");
    AST_DIS_CAUSE: assert property ($rose(DISCHARGE) |->
        $past(wr_req, 2) || $past(wr_req, 3) || $past(wr_req, 4)) else $error("discharge without write");
    AST_SEL_DEC: assert property ({PWM_SEL, PFM_SEL, SKIP_SEL} ==
        {OP_MODE == BKR_OP_PWM, OP_MODE == BKR_OP_PFM, OP_MODE == BKR_OP_SKIP}) else $error("mode decode wrong");
    AST_EN_MODE: assert property (REG_EN |-> OP_MODE != BKR_OP_OFF) else $error("enabled in off mode");
    AST_IRQ_HOLD: assert property (!IRQ_OUT_N && !wr_req && !$past(wr_req) && !$past(wr_req, 2)
        |=> !IRQ_OUT_N) else $error("interrupt dropped without write");
    AST_VOUT_STBY: assert property ($changed(STANDBY) |=> $stable(VOUT_MV)[*4])
        else $error("voltage moved on state change");
endmodule : bkr_top_sva

bind bkr_top bkr_top_sva #(.DISCH_CYCLES(DISCH_CYCLES)) chk_u (
    .MCLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ACK_O, .STANDBY, .REG_EN, .DISCHARGE,
    .OP_MODE, .PWM_SEL, .PFM_SEL, .SKIP_SEL, .VOUT_MV, .IRQ_OUT_N
);

//--- bkr_top_bench.sv
// Self-checking bench for the buck configuration block
`timescale 1ns/1ps
module bkr_top_bench
    import bkr_pkg::*;
;
    logic        mclk, rst, cyc, stb, we, sys_on, stby, seq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, dat_o, q;
    logic        ack_o, reg_en, dis, pwm, pfm, skip, rsvd, irq_n;
    logic [4:0]  vfuse;
    logic [2:0]  pfuse;
    logic [1:0]  ifuse, op_mode;
    logic [12:0] vout, peak;
    logic [8:0]  phase;
    logic [10:0] ind_nh;
    int          error_cnt, n_compared;
    int          v_code[6] = '{0, 8, 17, 26, 27, 31};
    int          v_mv[6]   = '{1000, 1800, 2800, 4000, 4100, 4100};
    int          pk_ma[4]  = '{2100, 2600, 3000, 4500};
    int          ind_t[4]  = '{1000, 470, 1500, 0};
    logic [1:0]  m_tab[4]  = '{2'h1, 2'h2, 2'h0, 2'h3};

    // Short discharge keeps the run brief
    bkr_top #(.DISCH_CYCLES(4)) dut_u (
        .MCLK(mclk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack_o), .SYS_ON(sys_on),
        .STANDBY(stby), .IN_PWRUP_SEQ(seq), .VOLT_DEFAULT_FUSE(vfuse), .PHASE_DEFAULT_FUSE(pfuse),
        .INDUCTOR_FUSE_SEL(ifuse), .REG_EN(reg_en), .DISCHARGE(dis), .OP_MODE(op_mode),
        .PWM_SEL(pwm), .PFM_SEL(pfm), .SKIP_SEL(skip), .VOUT_MV(vout), .PEAK_LIMIT_MA(peak),
        .PHASE_DEG(phase), .INDUCTOR_NH(ind_nh), .INDUCTOR_RSVD(rsvd), .IRQ_OUT_N(irq_n)
    );

    always #50 mclk = ~mclk;

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // Outputs read right after an edge show the settled pre-edge values
    task automatic wait_hi(ref logic s, input string what);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        chk(what, 32'h1, {31'h0, s});
    endtask : wait_hi

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'h3;
        wdat <= d;
        @(posedge mclk);
        wait_hi(ack_o, "ack");
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        sel <= 4'h0;
        @(posedge mclk);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask : wr

    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        mclk = 1'b0;
        rst  = 1'b1;
        {cyc, stb, we, adr, sel, wdat} = '0;
        {sys_on, stby, seq, vfuse, pfuse, ifuse} = {3'b101, 5'h1b, 3'h2, 2'h1};
        tick(12);
        rst <= 1'b0;
        tick(8);
        chk("vout", 4100, vout); // fuse code loaded
        chk("phase", 135, phase); // fuse phase loaded
        wb(1'b0, BKR_OFS_MODE, 32'h0, q);
        chk("modes", 32'hf, q[3:0]); // strap loads 11
        wb(1'b0, 8'h20, 32'h0, q);
        chk("unmapped", 32'h0, q);
        wr(BKR_OFS_IRQ, 32'h1);
        foreach (m_tab[i])
        begin
            wr(BKR_OFS_MODE, {28'h0, 2'h3, m_tab[i]});
            tick(3);
            chk("op_mode", m_tab[i], op_mode); // mode decode
            chk("sels", {m_tab[i] == 1, m_tab[i] == 2, m_tab[i] == 3}, {pwm, pfm, skip});
            chk("reg_en", m_tab[i] != 0, reg_en); // off disables
            chk("irq_n", 32'h0, irq_n); // change raises interrupt
            wb(1'b0, BKR_OFS_IRQ, 32'h0, q); // read flag
            chk("flag", 32'h1, q); // flag set
            wr(BKR_OFS_IRQ, 32'h1);
            tick(2);
            chk("irq_n", 32'h1, irq_n); // cleared
        end
        wr(BKR_OFS_IRQ, 32'h100);
        wr(BKR_OFS_MODE, 32'h09);
        tick(3);
        chk("irq_n", 32'h1, irq_n); // masked source
        wb(1'b0, BKR_OFS_IRQ, 32'h0, q); // read flag and mask
        chk("irqreg", 32'h101, q); // flag still set
        wr(BKR_OFS_IRQ, 32'h1);
        foreach (v_code[i])
        begin
            wr(BKR_OFS_VOLT, v_code[i]);
            wait_hi(dis, "dis"); // discharge first
            chk("en_dis", 32'h0, reg_en); // off while discharging
            chk("vold", i == 0 ? 4100 : v_mv[i - 1], vout); // old code kept
            wait_hi(reg_en, "reen"); // re-enabled
            tick(1);
            chk("vnew", v_mv[i], vout); // lookup and saturation
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(BKR_OFS_CFG, (i << BKR_POS_PHASE) | (i & 3));
            tick(3);
            chk("phase", i == 7 ? 0 : 45 * (i + 1), phase); // phase table
            chk("peak", pk_ma[i & 3], peak); // limit table
        end
        for (int i = 0; i < 4; i++)
        begin
            ifuse <= i[1:0];
            tick(5);
            chk("ind", ind_t[i], ind_nh); // inductor table
            chk("rsvd", i == 3, rsvd); // reserved code
        end
        stby <= 1'b1;
        tick(6);
        chk("op_stby", 32'h2, op_mode); // standby field applies
        chk("v_stby", 4100, vout); // voltage kept
        stby <= 1'b0;
        tick(6);
        chk("op_run", 32'h1, op_mode); // run field back
        wr(BKR_OFS_MODE, 32'h01);
        stby <= 1'b1;
        tick(6);
        chk("en_stby", 32'h0, reg_en); // standby field disables
        wb(1'b0, BKR_OFS_STAT, 32'h0, q); // status read
        chk("stat", 32'h1f64, q); // standby, off, code kept
        stby <= 1'b0;
        seq  <= 1'b0;
        rst  <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(8);
        wb(1'b0, BKR_OFS_MODE, 32'h0, q); // read modes
        chk("modes0", 32'h0, q & 32'hf); // no strap loads 00
        chk("en0", 32'h0, reg_en); // off without strap
        end_of_test();
    end
endmodule : bkr_top_bench
